// ==== bench/fpsc_partner.sv ====
// Far side of the panel: operator on the setup button, drop/insert gear on frame lock.
// Assumes its tasks are called from a process clocked by mclk_in.
`default_nettype none

module fpsc_partner (
	input  wire logic mclk_in,
	output var  logic button_n_out,
	output var  logic frame_sync_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		button_n_out = 1'b1;
		frame_sync_out = 1'b1;
	end

	// Button held down for a whole number of cycles, then let go
	task automatic press(input int cyc);
		@(posedge mclk_in);
		button_n_out <= 1'b0;
		repeat (cyc) @(posedge mclk_in);
		button_n_out <= 1'b1;
	endtask : press

	task automatic set_sync(input logic v);
		@(posedge mclk_in);
		frame_sync_out <= v;
	endtask : set_sync

endmodule : fpsc_partner

`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench of the front-panel supervisor: lamps, button modes, registers, arbiter.
// Assumes shortened tick, window and press parameters and the far-side model beside it.
`default_nettype none

module tb
	import fpsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Design and far side
	// ----------------------------------------------------------------
	localparam logic [9:0] ROWS [6] = '{10'h3ff, 10'h296, 10'h14a, 10'h108, 10'h023, 10'h063};
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, btn_n, sync;
	logic [7:0]  pa = 8'h00;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic        rdy, err, er, drun = 1'b0, dpass = 1'b0, operator_attention_lamp = 1'b0, flt = 1'b0, eth = 1'b0;
	logic        onl = 1'b0, bootd = 1'b0, dtx = 1'b0, rq0 = 1'b0, rq1 = 1'b0, q;
	logic [1:0]  jmp = 2'h0;
	logic [3:0]  pst = 4'hf;
	logic        l_operator_attention_lamp, l_hlth, l_act, l_set, l_lock, l_onl, dtx_o, mrst, smode, cons;
	logic        g0, g1, irq;
	logic [2:0]  l_ch;
	int          bad_count = 0, checks = 0, n, tog [3];

	always #4 clk = ~clk;

	fpsc_top #(.TICK_CYCLES(4), .SETUP_WINDOW_TICKS(100), .RESET_PRESS_TICKS(50)) fpsc_top_inst (
		.mclk_in(clk), .resetn_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(pa), .pwdata_in(pwd), .pstrb_in(pst), .prdata_out(prd), .pready_out(rdy),
		.pslverr_out(err), .setup_button_n_in(btn_n), .diag_running_in(drun),
		.diag_pass_in(dpass), .attention_req_in(operator_attention_lamp), .fault_in(flt), .eth_frame_ok_in(eth),
		.chan_jumper_in(jmp), .frame_sync_in(sync), .t1_online_in(onl), .boot_done_in(bootd),
		.di_tx_data_in(dtx), .cpu0_mem_req_in(rq0), .cpu1_mem_req_in(rq1),
		.operator_attention_lamp_out(l_operator_attention_lamp), .health_lamp_out(l_hlth),
		.backplane_activity_lamp_out(l_act), .setup_lamp_out(l_set), .chan_lamps_out(l_ch),
		.tributary_frame_lock_lamp_out(l_lock), .online_lamp_out(l_onl),
		.di_tx_data_out(dtx_o), .module_reset_out(mrst), .setup_mode_out(smode),
		.console_enable_out(cons), .mem_grant0_out(g0), .mem_grant1_out(g1), .irq_out(irq));

	fpsc_partner fpsc_partner_inst (.mclk_in(clk), .button_n_out(btn_n), .frame_sync_out(sync));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		pst <= s;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = prd;
		er = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	// Counts toggles of the setup, health and attention lamps
	task automatic watch(input int cyc);
		logic [2:0] p, c;
		tog = '{0, 0, 0};
		p = {l_operator_attention_lamp, l_hlth, l_set};
		repeat (cyc) begin
			@(negedge clk);
			c = {l_operator_attention_lamp, l_hlth, l_set} ^ p;
			p ^= c;
			foreach (tog[i]) tog[i] += c[i];
		end
	endtask : watch

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		$display("Error watchdog expected finish seen timeout");
		conclude();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("setup_mode", smode, 1'b0);
		chk("module_reset", mrst, 1'b0);
		chk("console", cons, 1'b1);
		foreach (ROWS[i]) begin
			@(posedge clk);
			operator_attention_lamp <= ROWS[i][9];
			onl <= ROWS[i][7];
			dtx <= ROWS[i][6];
			dpass <= ROWS[i][5];
			fpsc_partner_inst.set_sync(ROWS[i][8]);
			repeat (3) @(negedge clk);
			chk("lamps", {l_operator_attention_lamp, l_lock, l_onl, dtx_o, l_hlth}, ROWS[i][4:0]);
		end
		$display("test lamp table done");
		fpsc_partner_inst.press(100);
		for (n = 0; n < 200 && smode !== 1'b1; n++)
			@(negedge clk);
		chk("setup_mode", smode, 1'b1);
		watch(200);
		chk("setup_lamp", l_set, 1'b1);
		chk("setup steady", tog[0], 0);
		chk("module_reset", mrst, 1'b0);
		@(posedge clk);
		bootd <= 1'b1;
		repeat (4) @(negedge clk);
		chk("console", cons, 1'b0);
		chk("setup_mode", smode, 1'b0);
		$display("test setup entry done");
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk("mask reset", rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", er, 1'b1);
		chk("unmapped data", rd, 32'h0);
		for (n = 0; n < 4; n++) begin
			@(posedge clk);
			jmp <= n[1:0];
			repeat (5) @(negedge clk);
			chk("chan lamps", l_ch, (4'h1 << n) & 4'h7);
		end
		apb(1'b1, ADDR_CTRL, 32'h3);
		repeat (3) @(negedge clk);
		chk("chan override", l_ch, 3'b010);
		apb(1'b1, ADDR_CTRL, 32'h0, 4'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl no strobe", rd, 32'h3);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h1);
		fpsc_partner_inst.set_sync(1'b1);
		fpsc_partner_inst.set_sync(1'b0);
		repeat (4) @(negedge clk);
		chk("irq", irq, 1'b1);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk("lof event", rd[0], 1'b1);
		@(negedge clk);
		chk("irq cleared", irq, 1'b0);
		$display("test registers done");
		@(posedge clk);
		eth <= 1'b1;
		@(posedge clk);
		eth <= 1'b0;
		repeat (20) @(negedge clk);
		chk("activity on", l_act, 1'b1);
		repeat (130) @(negedge clk);
		chk("activity off", l_act, 1'b0);
		@(posedge clk);
		rq1 <= 1'b1;
		@(negedge clk);
		chk("lone grant", {g0, g1}, 2'b01);
		@(posedge clk);
		rq0 <= 1'b1;
		@(negedge clk);
		chk("first shared grant", {g0, g1}, 2'b10);
		q = 1'b1;
		for (n = 1; n < 5; n++) begin
			@(negedge clk);
			chk("grant", {g0, g1}, {q ^ n[0], ~(q ^ n[0])});
		end
		$display("test activity and arbiter done");
		@(posedge clk);
		flt <= 1'b1;
		bootd <= 1'b0;
		drun <= 1'b1;
		fork
			fpsc_partner_inst.press(2500);
			begin
				repeat (320) @(negedge clk);
				chk("module_reset", mrst, 1'b1);
				watch(2100);
				chk("health blink", tog[1] >= 2, 1'b1);
				chk("attention blink", tog[2] >= 2, 1'b1);
			end
		join
		for (n = 0; n < 300 && mrst !== 1'b0; n++)
			@(negedge clk);
		chk("module_reset", mrst, 1'b0);
		chk("console", cons, 1'b1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("diag state", rd[STAT_STATE_LSB +: 4], FPSC_DIAG);
		chk("window reopened", rd[STAT_WIN_BIT], 1'b1);
		watch(2100);
		chk("setup blink", tog[0] >= 2, 1'b1);
		@(posedge clk);
		drun <= 1'b0;
		flt <= 1'b0;
		repeat (450) @(negedge clk);
		chk("setup_lamp", l_set, 1'b0);
		$display("test reboot done");
		fpsc_partner_inst.press(100);
		repeat (100) @(negedge clk);
		chk("late press", smode, 1'b0);
		$display("test late press done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(negedge clk);
		chk("reset lamps", {l_operator_attention_lamp, l_hlth, l_set, l_ch}, 6'h00);
		chk("reset outs", {dtx_o, cons, irq, prd[0]}, 4'hc);
		@(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("setup_mode", smode, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("normal state", rd[STAT_STATE_LSB +: 4], FPSC_NORMAL);
		chk("window open", rd[STAT_WIN_BIT], 1'b1);
		$display("test mid-run reset done");
		conclude();
	end

endmodule : tb

`default_nettype wire

// ==== logic/fpsc_debounce.sv ====
// Setup pushbutton conditioner: two-stage synchroniser and tick-based debounce.
// Assumes an active-low button pin and a one-cycle tick from the prescaler.
`default_nettype none

module fpsc_debounce
	import fpsc_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic resetn_in,
	input  wire logic tick_in,
	input  wire logic button_n_in,
	output var  logic pressed_out
);

	logic             sync1_r;
	logic             sync2_r;
	logic             pressed_r;
	logic             pressed_nxt;
	logic [TMR_W-1:0] stab_cnt_r;
	logic [TMR_W-1:0] stab_cnt_nxt;

	// ----------------------------------------------------------------
	// Debounce
	// ----------------------------------------------------------------
	always_comb begin
		pressed_nxt  = pressed_r;
		stab_cnt_nxt = stab_cnt_r;
		if (!sync2_r == pressed_r) begin
			stab_cnt_nxt = '0;
		end else if (tick_in) begin
			if (stab_cnt_r == DEBOUNCE_TICKS - 1'b1) begin
				pressed_nxt  = !sync2_r;
				stab_cnt_nxt = '0;
			end else begin
				stab_cnt_nxt = stab_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_r    <= 1'b1;
			sync2_r    <= 1'b1;
			pressed_r  <= 1'b0;
			stab_cnt_r <= '0;
		end else begin
			sync1_r    <= button_n_in;
			sync2_r    <= sync1_r;
			pressed_r  <= pressed_nxt;
			stab_cnt_r <= stab_cnt_nxt;
		end
	end

	assign pressed_out = pressed_r;

endmodule : fpsc_debounce

`default_nettype wire

// ==== logic/fpsc_pkg.sv ====
// Constants, field layouts, register map and state codes of the front-panel supervisor.
// Assumes a single 125 MHz system clock; shared by the top level and the debouncer.
`default_nettype none

package fpsc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS          = 8;
	localparam int unsigned TICK_PERIOD_NS         = 1000000;
	localparam int unsigned TICK_CYCLES_DEF        = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_S            = 1000000000 / TICK_PERIOD_NS;
	localparam int unsigned SETUP_WINDOW_S         = 30;
	localparam int unsigned RESET_PRESS_S          = 3;
	localparam int unsigned SETUP_WINDOW_TICKS_DEF = SETUP_WINDOW_S * TICKS_PER_S;
	localparam int unsigned RESET_PRESS_TICKS_DEF  = RESET_PRESS_S * TICKS_PER_S;
	localparam int          PRESC_W                = 20;
	localparam int          TMR_W                  = 16;
	localparam logic [TMR_W-1:0] DEBOUNCE_TICKS    = 16'h0014;
	localparam logic [TMR_W-1:0] RESET_HOLD_TICKS  = 16'h0064;
	localparam logic [TMR_W-1:0] ACT_PULSE_TICKS   = 16'h001e;
	localparam int          BLINK_BIT              = 8;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0c;
	localparam int          CTRL_OVR_BIT  = 0;
	localparam int          CTRL_SEL_LSB  = 1;
	localparam logic [2:0]  CTRL_RESET    = 3'h0;
	localparam int          IRQ_LOF       = 0;
	localparam int          IRQ_SYNC      = 1;
	localparam int          IRQ_SETUP     = 2;
	localparam int          IRQ_LONGPRESS = 3;
	localparam int          IRQ_W         = 4;
	localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;
	localparam int          STAT_STATE_LSB = 0;
	localparam int          STAT_LOCK_BIT  = 4;
	localparam int          STAT_WIN_BIT   = 5;
	localparam int          STAT_BOOT_BIT  = 6;
	localparam int          STAT_CHAN_LSB  = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		FPSC_NORMAL = 4'h1,
		FPSC_SETUP  = 4'h2,
		FPSC_RESET  = 4'h4,
		FPSC_DIAG   = 4'h8
	} fpsc_state_t;

	localparam logic [1:0] CHAN_A = 2'h0;
	localparam logic [1:0] CHAN_B = 2'h1;
	localparam logic [1:0] CHAN_C = 2'h2;

endpackage : fpsc_pkg

`default_nettype wire

// ==== logic/fpsc_top.sv ====
// Front-panel supervisor: lamps, setup pushbutton, keep-alive, memory arbiter, APB registers.
// Assumes status inputs come from logic on mclk_in; button and jumpers are raw pins.
`default_nettype none

module fpsc_top
	import fpsc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES        = TICK_CYCLES_DEF,
	parameter int unsigned SETUP_WINDOW_TICKS = SETUP_WINDOW_TICKS_DEF,
	parameter int unsigned RESET_PRESS_TICKS  = RESET_PRESS_TICKS_DEF
) (
	input  wire logic              mclk_in,
	input  wire logic              resetn_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]       pwdata_in,
	input  wire logic [3:0]        pstrb_in,
	output var  logic [31:0]       prdata_out,
	output var  logic              pready_out,
	output var  logic              pslverr_out,
	input  wire logic              setup_button_n_in,
	input  wire logic              diag_running_in,
	input  wire logic              diag_pass_in,
	input  wire logic              attention_req_in,
	input  wire logic              fault_in,
	input  wire logic              eth_frame_ok_in,
	input  wire logic [1:0]        chan_jumper_in,
	input  wire logic              frame_sync_in,
	input  wire logic              t1_online_in,
	input  wire logic              boot_done_in,
	input  wire logic              di_tx_data_in,
	input  wire logic              cpu0_mem_req_in,
	input  wire logic              cpu1_mem_req_in,
	output var  logic              operator_attention_lamp_out,
	output var  logic              health_lamp_out,
	output var  logic              backplane_activity_lamp_out,
	output var  logic              setup_lamp_out,
	output var  logic [2:0]        chan_lamps_out,
	output var  logic              tributary_frame_lock_lamp_out,
	output var  logic              online_lamp_out,
	output var  logic              di_tx_data_out,
	output var  logic              module_reset_out,
	output var  logic              setup_mode_out,
	output var  logic              console_enable_out,
	output var  logic              mem_grant0_out,
	output var  logic              mem_grant1_out,
	output var  logic              irq_out
);

	localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);
	localparam logic [TMR_W-1:0]   WIN_LAST   = TMR_W'(SETUP_WINDOW_TICKS);
	localparam logic [TMR_W-1:0]   PRESS_LAST = TMR_W'(RESET_PRESS_TICKS);

	fpsc_state_t        state_r, state_nxt;
	logic [PRESC_W-1:0] presc_r, presc_nxt;
	logic [TMR_W-1:0]   blink_cnt_r, blink_cnt_nxt;
	logic [TMR_W-1:0]   press_cnt_r, press_cnt_nxt;
	logic [TMR_W-1:0]   win_cnt_r, win_cnt_nxt;
	logic [TMR_W-1:0]   hold_cnt_r, hold_cnt_nxt;
	logic [TMR_W-1:0]   act_cnt_r, act_cnt_nxt;
	logic               pressed_q_r, booted_r, booted_nxt;
	logic               lock_q_r, last_cpu1_r, last_cpu1_nxt;
	logic [1:0]         jmp_s1_r, jmp_s2_r;
	logic               tick, blink, pressed, press_edge, long_press, window_open;
	logic [1:0]         chan_sel;
	logic [2:0]         chan_dec;
	logic [2:0]         ctrl_r, ctrl_nxt;
	logic [IRQ_W-1:0]   irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt, irq_ev;
	logic [31:0]        rdata_r, rdata_nxt, status_word;
	logic               setup_ph, access_ph, addr_ok;

	// ----------------------------------------------------------------
	// Button conditioning
	// ----------------------------------------------------------------
	fpsc_debounce u_button (
		.mclk_in     (mclk_in),
		.resetn_in   (resetn_in),
		.tick_in     (tick),
		.button_n_in (setup_button_n_in),
		.pressed_out (pressed)
	);

	// ----------------------------------------------------------------
	// Prescaler, timers and mode sequencer
	// ----------------------------------------------------------------
	assign tick        = (presc_r == PRESC_LAST);
	assign blink       = blink_cnt_r[BLINK_BIT];
	assign press_edge  = pressed && !pressed_q_r;
	assign long_press  = pressed && tick && (press_cnt_r == PRESS_LAST - 1'b1);
	assign window_open = (win_cnt_r != WIN_LAST) && !booted_r;

	always_comb begin
		presc_nxt     = tick ? '0 : presc_r + 1'b1;
		blink_cnt_nxt = tick ? blink_cnt_r + 1'b1 : blink_cnt_r;
		press_cnt_nxt = press_cnt_r;
		win_cnt_nxt   = win_cnt_r;
		hold_cnt_nxt  = hold_cnt_r;
		act_cnt_nxt   = act_cnt_r;
		booted_nxt    = booted_r;
		state_nxt     = state_r;
		if (!pressed) begin
			press_cnt_nxt = '0;
		end else if (tick && press_cnt_r != PRESS_LAST) begin
			press_cnt_nxt = press_cnt_r + 1'b1;
		end
		if (tick && win_cnt_r != WIN_LAST) begin
			win_cnt_nxt = win_cnt_r + 1'b1;
		end
		if (eth_frame_ok_in) begin
			act_cnt_nxt = ACT_PULSE_TICKS;
		end else if (tick && act_cnt_r != '0) begin
			act_cnt_nxt = act_cnt_r - 1'b1;
		end
		if (boot_done_in && state_r != FPSC_RESET) begin
			booted_nxt = 1'b1;
		end
		case (state_r)
			FPSC_NORMAL: begin
				if (press_edge && window_open) begin
					state_nxt = FPSC_SETUP;
				end
			end
			FPSC_DIAG: begin
				if (press_edge && window_open) begin
					state_nxt = FPSC_SETUP;
				end else if (!diag_running_in) begin
					state_nxt = FPSC_NORMAL;
				end
			end
			FPSC_SETUP: begin
				if (boot_done_in) begin
					state_nxt = FPSC_NORMAL;
				end
			end
			FPSC_RESET: begin
				win_cnt_nxt = '0;
				if (tick && hold_cnt_r != RESET_HOLD_TICKS) begin
					hold_cnt_nxt = hold_cnt_r + 1'b1;
				end
				if (hold_cnt_r == RESET_HOLD_TICKS && !pressed) begin
					state_nxt = FPSC_DIAG;
				end
			end
			default: begin
				state_nxt = FPSC_NORMAL;
			end
		endcase
		if (long_press) begin
			state_nxt    = FPSC_RESET;
			hold_cnt_nxt = '0;
			win_cnt_nxt  = '0;
			booted_nxt   = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r     <= FPSC_NORMAL;
			presc_r     <= '0;
			blink_cnt_r <= '0;
			press_cnt_r <= '0;
			win_cnt_r   <= '0;
			hold_cnt_r  <= '0;
			act_cnt_r   <= '0;
			booted_r    <= 1'b0;
			pressed_q_r <= 1'b0;
			lock_q_r    <= 1'b1;
		end else begin
			state_r     <= state_nxt;
			presc_r     <= presc_nxt;
			blink_cnt_r <= blink_cnt_nxt;
			press_cnt_r <= press_cnt_nxt;
			win_cnt_r   <= win_cnt_nxt;
			hold_cnt_r  <= hold_cnt_nxt;
			act_cnt_r   <= act_cnt_nxt;
			booted_r    <= booted_nxt;
			pressed_q_r <= pressed;
			lock_q_r    <= frame_sync_in;
		end
	end

	// ----------------------------------------------------------------
	// Lamps and port outputs
	// ----------------------------------------------------------------
	assign chan_sel = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_SEL_LSB +: 2] : jmp_s2_r;

	generate
		for (genvar c = 0; c < 3; c++) begin : g_chan
			assign chan_dec[c] = (chan_sel == 2'(c));
		end
	endgenerate

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			jmp_s1_r                      <= '0;
			jmp_s2_r                      <= '0;
			operator_attention_lamp_out   <= 1'b0;
			health_lamp_out               <= 1'b0;
			backplane_activity_lamp_out   <= 1'b0;
			setup_lamp_out                <= 1'b0;
			chan_lamps_out                <= '0;
			tributary_frame_lock_lamp_out <= 1'b0;
			online_lamp_out               <= 1'b0;
			di_tx_data_out                <= 1'b1;
			module_reset_out              <= 1'b0;
			setup_mode_out                <= 1'b0;
			console_enable_out            <= 1'b1;
		end else begin
			jmp_s1_r                      <= chan_jumper_in;
			jmp_s2_r                      <= jmp_s1_r;
			operator_attention_lamp_out   <= fault_in ? blink : attention_req_in;
			health_lamp_out               <= (state_r == FPSC_RESET) ? blink : diag_pass_in;
			backplane_activity_lamp_out   <= (act_cnt_r != '0);
			setup_lamp_out                <= (state_r == FPSC_SETUP) ||
				((state_r == FPSC_RESET || (state_r == FPSC_DIAG && diag_running_in))
				&& blink);
			chan_lamps_out                <= chan_dec;
			tributary_frame_lock_lamp_out <= frame_sync_in;
			online_lamp_out               <= t1_online_in;
			di_tx_data_out                <= frame_sync_in ? di_tx_data_in : 1'b1;
			module_reset_out              <= (state_nxt == FPSC_RESET);
			setup_mode_out                <= (state_nxt == FPSC_SETUP);
			console_enable_out            <= !booted_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Shared memory arbiter
	// ----------------------------------------------------------------
	always_comb begin
		mem_grant0_out = cpu0_mem_req_in && (!cpu1_mem_req_in || last_cpu1_r);
		mem_grant1_out = cpu1_mem_req_in && !mem_grant0_out;
		last_cpu1_nxt  = mem_grant1_out ? 1'b1 : (mem_grant0_out ? 1'b0 : last_cpu1_r);
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			last_cpu1_r <= 1'b1;
		end else begin
			last_cpu1_r <= last_cpu1_nxt;
		end
	end

	// ----------------------------------------------------------------
	// APB registers and interrupt
	// ----------------------------------------------------------------
	assign setup_ph  = psel_in && !penable_in;
	assign access_ph = psel_in && penable_in;
	assign addr_ok   = (paddr_in == ADDR_CTRL) || (paddr_in == ADDR_STATUS) ||
		(paddr_in == ADDR_IRQ_STAT) || (paddr_in == ADDR_IRQ_MASK);
	assign pready_out  = 1'b1;
	assign pslverr_out = access_ph && !addr_ok;
	assign prdata_out  = rdata_r;
	assign irq_out     = |(irq_stat_r & irq_mask_r);

	always_comb begin
		status_word = '0;
		status_word[STAT_STATE_LSB +: 4] = state_r;
		status_word[STAT_LOCK_BIT]       = lock_q_r;
		status_word[STAT_WIN_BIT]        = window_open;
		status_word[STAT_BOOT_BIT]       = booted_r;
		status_word[STAT_CHAN_LSB +: 3]  = chan_lamps_out;
		irq_ev = '0;
		irq_ev[IRQ_LOF]       = lock_q_r && !frame_sync_in;
		irq_ev[IRQ_SYNC]      = !lock_q_r && frame_sync_in;
		irq_ev[IRQ_SETUP]     = (state_nxt == FPSC_SETUP) && (state_r != FPSC_SETUP);
		irq_ev[IRQ_LONGPRESS] = long_press;
		ctrl_nxt     = ctrl_r;
		irq_mask_nxt = irq_mask_r;
		irq_stat_nxt = irq_stat_r;
		rdata_nxt    = rdata_r;
		if (setup_ph && !pwrite_in) begin
			case (paddr_in)
				ADDR_CTRL:     rdata_nxt = {29'h0, ctrl_r};
				ADDR_STATUS:   rdata_nxt = status_word;
				ADDR_IRQ_STAT: rdata_nxt = {28'h0, irq_stat_r};
				ADDR_IRQ_MASK: rdata_nxt = {28'h0, irq_mask_r};
				default:       rdata_nxt = '0;
			endcase
		end
		if (access_ph && pwrite_in && pstrb_in[0]) begin
			if (paddr_in == ADDR_CTRL) begin
				ctrl_nxt = pwdata_in[2:0];
			end
			if (paddr_in == ADDR_IRQ_MASK) begin
				irq_mask_nxt = pwdata_in[IRQ_W-1:0];
			end
		end
		if (access_ph && !pwrite_in && paddr_in == ADDR_IRQ_STAT) begin
			irq_stat_nxt = irq_stat_r & ~rdata_r[IRQ_W-1:0];
		end
		irq_stat_nxt = irq_stat_nxt | irq_ev;
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_r     <= CTRL_RESET;
			irq_mask_r <= IRQ_MASK_RESET;
			irq_stat_r <= '0;
			rdata_r    <= '0;
		end else begin
			ctrl_r     <= ctrl_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_stat_r <= irq_stat_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	property p_keepalive;
		!frame_sync_in |=> di_tx_data_out;
	endproperty
	a_keepalive: assert property (p_keepalive) else $error("keep-alive not sent");

	property p_lock_lamp;
		resetn_in |=> tributary_frame_lock_lamp_out == $past(frame_sync_in);
	endproperty
	a_lock_lamp: assert property (p_lock_lamp) else $error("frame lock lamp wrong");

	property p_online;
		resetn_in && $changed(t1_online_in) |=> online_lamp_out == $past(t1_online_in);
	endproperty
	a_online: assert property (p_online) else $error("online lamp wrong");

	property p_setup_lamp;
		state_r == FPSC_SETUP |=> setup_lamp_out;
	endproperty
	a_setup_lamp: assert property (p_setup_lamp) else $error("setup lamp dark");

	property p_operator_attention_lamp;
		resetn_in && fault_in |=> operator_attention_lamp_out == $past(blink);
	endproperty
	a_operator_attention_lamp: assert property (p_operator_attention_lamp) else $error("attention lamp not blinking");

	property p_mem_fair;
		(resetn_in && mem_grant0_out) ##1 (cpu0_mem_req_in && cpu1_mem_req_in) |-> mem_grant1_out;
	endproperty
	a_mem_fair: assert property (p_mem_fair) else $error("arbiter not alternating");

	property p_mem_excl;
		!(mem_grant0_out && mem_grant1_out);
	endproperty
	a_mem_excl: assert property (p_mem_excl) else $error("double memory grant");

	property p_late_press;
		state_r == FPSC_NORMAL && !window_open && !long_press |=> state_r != FPSC_SETUP;
	endproperty
	a_late_press: assert property (p_late_press) else $error("setup after window");

	property p_long_press;
		long_press |=> state_r == FPSC_RESET ##1 module_reset_out;
	endproperty
	a_long_press: assert property (p_long_press) else $error("long press ignored");

	property p_console;
		booted_r && !long_press |-> ##1 !console_enable_out;
	endproperty
	a_console: assert property (p_console) else $error("console active after boot");

	property p_chan;
		##1 $onehot0(chan_lamps_out);
	endproperty
	a_chan: assert property (p_chan) else $error("channel lamps not one-hot");

	c_setup: cover property (state_r == FPSC_NORMAL ##1 state_r == FPSC_SETUP);
	c_reboot: cover property (state_r == FPSC_RESET ##1 state_r == FPSC_DIAG);
	c_lof_irq: cover property (irq_ev[IRQ_LOF] ##1 irq_out);

endmodule : fpsc_top

`default_nettype wire
